// file: core/nibble_alu_pkg.sv
package nibble_alu_pkg;

  // Datapath widths
  localparam int NIBBLE_W = 4;
  localparam int BYTE_W = 8;
  localparam int BIT_SEL_W = 2;
  localparam int TABLE_ADDR_W = 3;
  localparam int PAGE_W = 5;
  localparam int PAGE_OFFSET_W = TABLE_ADDR_W + NIBBLE_W;
  localparam int ROM_ADDR_W = PAGE_W + PAGE_OFFSET_W;
  localparam int OP_W = 5;

  // Field positions inside a fetched ROM byte
  localparam int ROM_HI_MSB = 7;
  localparam int ROM_HI_LSB = 4;
  localparam int ROM_LO_MSB = 3;
  localparam int ROM_LO_LSB = 0;

  // Reset values
  localparam logic [NIBBLE_W-1:0] ACC_RESET = 4'h0;
  localparam logic [NIBBLE_W-1:0] UPPER_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;

  // Fixed flag values
  localparam logic CARRY_SET_VALUE = 1'b1;
  localparam logic CARRY_CLEAR_VALUE = 1'b0;

  // Stack levels a table read occupies
  localparam int TABLE_STACK_LEVELS = 1;

  // Decoded operations handed over by the instruction decoder
  typedef enum logic [OP_W-1:0] {
    OP_NONE = 5'h00,
    OP_LOAD_IMMEDIATE = 5'h01,
    OP_ROM_TABLE_READ = 5'h02,
    OP_ADD_MEMORY = 5'h03,
    OP_ADD_WITH_CARRY = 5'h04,
    OP_ADD_IMMEDIATE = 5'h05,
    OP_AND_MEMORY = 5'h06,
    OP_OR_MEMORY = 5'h07,
    OP_SET_CARRY = 5'h08,
    OP_CLEAR_CARRY = 5'h09,
    OP_SKIP_IF_CARRY_ZERO = 5'h0a,
    OP_INVERT_ACCUMULATOR = 5'h0b,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0c,
    OP_SET_BIT = 5'h0d,
    OP_CLEAR_BIT = 5'h0e,
    OP_SKIP_IF_BIT_ZERO = 5'h0f,
    OP_SKIP_IF_EQUAL_MEMORY = 5'h10,
    OP_SKIP_IF_EQUAL_IMMEDIATE = 5'h11
  } op_t;

  // Table read sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } table_state_t;

endpackage

// file: core/nibble_adder.sv
`timescale 1ns/1ps
module nibble_adder (
  input wire logic [nibble_alu_pkg::NIBBLE_W-1:0] a_i,
  input wire logic [nibble_alu_pkg::NIBBLE_W-1:0] b_i,
  input wire logic carry_i,
  output logic [nibble_alu_pkg::NIBBLE_W-1:0] sum_o,
  output logic carry_o
);
  import nibble_alu_pkg::*;

  logic [NIBBLE_W:0] wide_sum;

  always_comb begin
    wide_sum = {1'b0, a_i} + {1'b0, b_i} + {{NIBBLE_W{1'b0}}, carry_i};
    sum_o = wide_sum[NIBBLE_W-1:0];
    carry_o = wide_sum[NIBBLE_W];
  end

endmodule // nibble_adder

// file: core/nibble_bit_mask.sv
`timescale 1ns/1ps
module nibble_bit_mask (
  input wire logic [nibble_alu_pkg::BIT_SEL_W-1:0] sel_i,
  input wire logic [nibble_alu_pkg::NIBBLE_W-1:0] value_i,
  output logic [nibble_alu_pkg::NIBBLE_W-1:0] mask_o,
  output logic bit_o
);
  import nibble_alu_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NIBBLE_W; g = g + 1) begin : g_mask
      assign mask_o[g] = (sel_i == BIT_SEL_W'(g));
    end
  endgenerate

  assign bit_o = |(value_i & mask_o);

endmodule // nibble_bit_mask

// file: core/nibble_alu_skip_logic.sv
`timescale 1ns/1ps
// How it works
// - Load immediate writes the accumulator
// - Consecutive load immediates after the first skip
// - Table byte: high nibble upper, low accumulator
// - Table address: page, pointer bits, accumulator
// - Table read borrows one stack level
// - Add memory to accumulator, carry kept
// - Add memory plus carry, carry out stored
// - Add immediate to accumulator, carry kept
// - Add immediate skips next unless overflow
// - AND memory into accumulator
// - OR memory into accumulator
// - Set carry to one
// - Clear carry to zero
// - Skip next when carry is zero
// - Invert accumulator
// - Rotate accumulator right through carry
// - Set selected bit of pointer memory
// - Clear selected bit of pointer memory
// - Skip next when selected bit zero
// - Skip next when accumulator equals memory
// - Skip next when accumulator equals immediate
module nibble_alu_skip_logic (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic issue_i,
  input wire nibble_alu_pkg::op_t op_i,
  input wire logic [nibble_alu_pkg::NIBBLE_W-1:0] imm_i,
  input wire logic [nibble_alu_pkg::PAGE_W-1:0] page_i,
  input wire logic [nibble_alu_pkg::TABLE_ADDR_W-1:0] table_addr_i,
  input wire logic [nibble_alu_pkg::NIBBLE_W-1:0] pointer_memory_operand_i,
  input wire logic [nibble_alu_pkg::BYTE_W-1:0] rom_data_i,
  output logic [nibble_alu_pkg::NIBBLE_W-1:0] acc_o,
  output logic [nibble_alu_pkg::NIBBLE_W-1:0] upper_nibble_o,
  output logic carry_flag_o,
  output logic skip_pending_o,
  output logic squashed_o,
  output logic mem_we_o,
  output logic [nibble_alu_pkg::NIBBLE_W-1:0] mem_wdata_o,
  output logic rom_req_o,
  output logic [nibble_alu_pkg::ROM_ADDR_W-1:0] rom_addr_o,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic busy_o
);
  import nibble_alu_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // State

  logic [NIBBLE_W-1:0] acc;
  logic [NIBBLE_W-1:0] upper_nibble;
  logic carry_flag;
  logic skip_pending;
  logic prev_was_load;
  logic squashed;
  logic mem_we;
  logic [NIBBLE_W-1:0] mem_wdata;
  logic rom_req;
  logic [ROM_ADDR_W-1:0] rom_addr;
  logic stack_push;
  logic stack_pop;
  table_state_t state;

  logic [NIBBLE_W-1:0] next_acc;
  logic [NIBBLE_W-1:0] next_upper_nibble;
  logic next_carry_flag;
  logic next_skip_pending;
  logic next_prev_was_load;
  logic next_squashed;
  logic next_mem_we;
  logic [NIBBLE_W-1:0] next_mem_wdata;
  logic next_rom_req;
  logic [ROM_ADDR_W-1:0] next_rom_addr;
  logic next_stack_push;
  logic next_stack_pop;
  table_state_t next_state;

  //////////////////////////////////////////////////////////////////////
  // Shared arithmetic

  logic [NIBBLE_W-1:0] add_b;
  logic add_cin;
  logic [NIBBLE_W-1:0] add_sum;
  logic add_cout;
  logic [NIBBLE_W-1:0] bit_mask;
  logic sel_bit;

  // One adder serves all three adds; only the operand and carry-in differ
  always_comb begin
    add_b = pointer_memory_operand_i;
    add_cin = 1'b0;
    if (op_i == OP_ADD_IMMEDIATE) begin
      add_b = imm_i;
    end
    if (op_i == OP_ADD_WITH_CARRY) begin
      add_cin = carry_flag;
    end
  end

  nibble_adder u_adder (
    .a_i(acc),
    .b_i(add_b),
    .carry_i(add_cin),
    .sum_o(add_sum),
    .carry_o(add_cout)
  );

  nibble_bit_mask u_bit_mask (
    .sel_i(imm_i[BIT_SEL_W-1:0]),
    .value_i(pointer_memory_operand_i),
    .mask_o(bit_mask),
    .bit_o(sel_bit)
  );

  //////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic is_load;
  logic do_squash;
  logic do_exec;

  always_comb begin
    is_load = (op_i == OP_LOAD_IMMEDIATE);
    // A load directly after a load is dropped like any skipped slot
    do_squash = issue_i && (state == ST_IDLE) && (skip_pending || (is_load && prev_was_load));
    do_exec = issue_i && (state == ST_IDLE) && !do_squash;

    next_acc = acc;
    next_upper_nibble = upper_nibble;
    next_carry_flag = carry_flag;
    next_skip_pending = skip_pending;
    next_prev_was_load = prev_was_load;
    next_squashed = 1'b0;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_rom_req = 1'b0;
    next_rom_addr = rom_addr;
    next_stack_push = 1'b0;
    next_stack_pop = 1'b0;
    next_state = state;

    if (issue_i && (state == ST_IDLE)) begin
      next_prev_was_load = is_load;
      next_skip_pending = 1'b0;
    end

    if (do_squash) begin
      next_squashed = 1'b1;
    end

    if (do_exec) begin
      case (op_i)
        OP_LOAD_IMMEDIATE: begin
          next_acc = imm_i;
        end
        OP_ROM_TABLE_READ: begin
          next_rom_addr = {page_i, table_addr_i, acc};
          next_rom_req = 1'b1;
          next_stack_push = 1'b1;
          next_state = ST_FETCH;
        end
        OP_ADD_MEMORY: begin
          next_acc = add_sum;
        end
        OP_ADD_WITH_CARRY: begin
          next_acc = add_sum;
          next_carry_flag = add_cout;
        end
        OP_ADD_IMMEDIATE: begin
          next_acc = add_sum;
          next_skip_pending = !add_cout;
        end
        OP_AND_MEMORY: begin
          next_acc = acc & pointer_memory_operand_i;
        end
        OP_OR_MEMORY: begin
          next_acc = acc | pointer_memory_operand_i;
        end
        OP_SET_CARRY: begin
          next_carry_flag = CARRY_SET_VALUE;
        end
        OP_CLEAR_CARRY: begin
          next_carry_flag = CARRY_CLEAR_VALUE;
        end
        OP_SKIP_IF_CARRY_ZERO: begin
          next_skip_pending = !carry_flag;
        end
        OP_INVERT_ACCUMULATOR: begin
          next_acc = ~acc;
        end
        OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          next_acc = {carry_flag, acc[NIBBLE_W-1:1]};
          next_carry_flag = acc[0];
        end
        OP_SET_BIT: begin
          next_mem_we = 1'b1;
          next_mem_wdata = pointer_memory_operand_i | bit_mask;
        end
        OP_CLEAR_BIT: begin
          next_mem_we = 1'b1;
          next_mem_wdata = pointer_memory_operand_i & ~bit_mask;
        end
        OP_SKIP_IF_BIT_ZERO: begin
          next_skip_pending = !sel_bit;
        end
        OP_SKIP_IF_EQUAL_MEMORY: begin
          next_skip_pending = (acc == pointer_memory_operand_i);
        end
        OP_SKIP_IF_EQUAL_IMMEDIATE: begin
          next_skip_pending = (acc == imm_i);
        end
        default: begin
          next_acc = acc;
        end
      endcase
    end

    // ROM data is sampled in the cycle the request is out; the stack level is returned one cycle later
    case (state)
      ST_IDLE: begin
        next_state = next_state;
      end
      ST_FETCH: begin
        next_upper_nibble = rom_data_i[ROM_HI_MSB:ROM_HI_LSB];
        next_acc = rom_data_i[ROM_LO_MSB:ROM_LO_LSB];
        next_stack_pop = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc <= ACC_RESET;
      upper_nibble <= UPPER_RESET;
      carry_flag <= CARRY_RESET;
      skip_pending <= 1'b0;
      prev_was_load <= 1'b0;
      squashed <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 4'h0;
      rom_req <= 1'b0;
      rom_addr <= 12'h000;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      state <= ST_IDLE;
    end else begin
      acc <= next_acc;
      upper_nibble <= next_upper_nibble;
      carry_flag <= next_carry_flag;
      skip_pending <= next_skip_pending;
      prev_was_load <= next_prev_was_load;
      squashed <= next_squashed;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      rom_req <= next_rom_req;
      rom_addr <= next_rom_addr;
      stack_push <= next_stack_push;
      stack_pop <= next_stack_pop;
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign acc_o = acc;
  assign upper_nibble_o = upper_nibble;
  assign carry_flag_o = carry_flag;
  assign skip_pending_o = skip_pending;
  assign squashed_o = squashed;
  assign mem_we_o = mem_we;
  assign mem_wdata_o = mem_wdata;
  assign rom_req_o = rom_req;
  assign rom_addr_o = rom_addr;
  assign stack_push_o = stack_push;
  assign stack_pop_o = stack_pop;
  // Busy is the fetch state flop itself
  assign busy_o = state[1];

endmodule // nibble_alu_skip_logic

// file: tb/nibble_alu_skip_sva.sv
`timescale 1ns/1ps
module nibble_alu_skip_sva
  import nibble_alu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic issue_i,
  input wire nibble_alu_pkg::op_t op_i,
  input wire logic [3:0] imm_i,
  input wire logic [4:0] page_i,
  input wire logic [2:0] table_addr_i,
  input wire logic [3:0] pointer_memory_operand_i,
  input wire logic [7:0] rom_data_i,
  input wire logic [3:0] acc_o,
  input wire logic [3:0] upper_nibble_o,
  input wire logic carry_flag_o,
  input wire logic skip_pending_o,
  input wire logic squashed_o,
  input wire logic mem_we_o,
  input wire logic [3:0] mem_wdata_o,
  input wire logic rom_req_o,
  input wire logic [11:0] rom_addr_o,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic busy_o
);
  logic prev_ld;
  logic go;
  assign go = issue_i && !busy_o && !skip_pending_o;
  // Skipped loads count too, so a run stays suppressed
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      prev_ld <= 1'b0;
    else if (issue_i && !busy_o)
      prev_ld <= (op_i == OP_LOAD_IMMEDIATE);
  end
  ////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  load_value_a: assert property (go && !prev_ld && op_i == OP_LOAD_IMMEDIATE |=> acc_o == $past(imm_i))
    else $error("load value wrong");
  load_run_a: assert property (issue_i && !busy_o && prev_ld && op_i == OP_LOAD_IMMEDIATE |=> squashed_o)
    else $error("repeated load not skipped");
  add_imm_a: assert property (go && op_i == OP_ADD_IMMEDIATE |=> acc_o == $past(acc_o + imm_i)
    && carry_flag_o == $past(carry_flag_o) && skip_pending_o == ($past(acc_o) + $past(imm_i) < 16))
    else $error("add immediate wrong");
  add_carry_a: assert property (go && op_i == OP_ADD_WITH_CARRY |=>
    {carry_flag_o, acc_o} == $past(acc_o) + $past(pointer_memory_operand_i) + $past(carry_flag_o))
    else $error("add with carry wrong");
  set_carry_a: assert property (go && op_i == OP_SET_CARRY |=> carry_flag_o && $stable(acc_o))
    else $error("set carry wrong");
  rotate_a: assert property (go && op_i == OP_ROTATE_RIGHT_THROUGH_CARRY |=>
    {carry_flag_o, acc_o} == {$past(acc_o[0]), $past(carry_flag_o), $past(acc_o[3:1])})
    else $error("rotate wrong");
  table_req_a: assert property (go && op_i == OP_ROM_TABLE_READ |=> rom_req_o && stack_push_o && busy_o
    && rom_addr_o == {$past(page_i), $past(table_addr_i), $past(acc_o)})
    else $error("table request wrong");
  table_load_a: assert property (rom_req_o |=> stack_pop_o && {upper_nibble_o, acc_o} == $past(rom_data_i))
    else $error("table load wrong");
  set_bit_a: assert property (go && op_i == OP_SET_BIT |=> mem_we_o
    && mem_wdata_o == ($past(pointer_memory_operand_i) | (4'h1 << $past(imm_i[1:0]))))
    else $error("set bit wrong");
  cmp_imm_a: assert property (go && op_i == OP_SKIP_IF_EQUAL_IMMEDIATE |=>
    skip_pending_o == ($past(acc_o) == $past(imm_i)))
    else $error("compare immediate wrong");
  squash_a: assert property (squashed_o |-> $stable(acc_o) && $stable(carry_flag_o) && !mem_we_o && !rom_req_o)
    else $error("skipped op changed state");
endmodule // nibble_alu_skip_sva
bind nibble_alu_skip_logic nibble_alu_skip_sva i_sva (.sys_clk_i, .rst_b_i, .issue_i, .op_i, .imm_i, .page_i,
  .table_addr_i, .pointer_memory_operand_i, .rom_data_i, .acc_o, .upper_nibble_o, .carry_flag_o, .skip_pending_o,
  .squashed_o, .mem_we_o, .mem_wdata_o, .rom_req_o, .rom_addr_o, .stack_push_o, .stack_pop_o, .busy_o);

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import nibble_alu_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic issue_i = 1'b0;
  op_t op_i = OP_NONE;
  logic [3:0] imm_i = 4'h0;
  logic [3:0] pointer_memory_operand_i = 4'h0;
  logic [4:0] page_i = 5'h00;
  logic [2:0] table_addr_i = 3'h0;
  logic [7:0] rom_data_i = 8'h00;
  logic [3:0] acc_o, upper_nibble_o, mem_wdata_o;
  logic [11:0] rom_addr_o;
  logic carry_flag_o, skip_pending_o, squashed_o, mem_we_o, rom_req_o, stack_push_o, stack_pop_o, busy_o;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  nibble_alu_skip_logic i_dut (.sys_clk_i, .rst_b_i, .issue_i, .op_i, .imm_i, .page_i, .table_addr_i,
    .pointer_memory_operand_i, .rom_data_i, .acc_o, .upper_nibble_o, .carry_flag_o, .skip_pending_o,
    .squashed_o, .mem_we_o, .mem_wdata_o, .rom_req_o, .rom_addr_o, .stack_push_o, .stack_pop_o, .busy_o);
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test;
    end
  end
  // Wide enough for the table request word with its three strobes
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // Issue stays high so back-to-back ops never toggle it twice
  task iss(input op_t o, input logic [3:0] n, input logic [3:0] m);
    op_i = o;
    imm_i = n;
    pointer_memory_operand_i = m;
    issue_i = 1'b1;
    @(negedge sys_clk_i);
  endtask
  ////////////////////////////////////////
  task t_load;
    iss(OP_LOAD_IMMEDIATE, 4'h5, 4'h0); chk(acc_o, 4'h5);
    iss(OP_LOAD_IMMEDIATE, 4'h9, 4'h0); chk({squashed_o, acc_o}, 5'h15);
    iss(OP_LOAD_IMMEDIATE, 4'h3, 4'h0); chk(acc_o, 4'h5);
  endtask
  task t_flags;
    iss(OP_SET_CARRY, 4'h0, 4'h0); chk(carry_flag_o, 1'b1);
    iss(OP_LOAD_IMMEDIATE, 4'hc, 4'h0);
    iss(OP_ADD_IMMEDIATE, 4'h3, 4'h0); chk({acc_o, carry_flag_o, skip_pending_o}, 6'h3f);
    iss(OP_CLEAR_CARRY, 4'h0, 4'h0); chk({squashed_o, carry_flag_o}, 2'h3);
    iss(OP_ADD_IMMEDIATE, 4'h2, 4'h0); chk({acc_o, skip_pending_o}, 5'h02);
    iss(OP_CLEAR_CARRY, 4'h0, 4'h0); chk(carry_flag_o, 1'b0);
    iss(OP_SKIP_IF_CARRY_ZERO, 4'h0, 4'h0); chk(skip_pending_o, 1'b1);
    iss(OP_INVERT_ACCUMULATOR, 4'h0, 4'h0); chk({squashed_o, acc_o}, 5'h11);
  endtask
  task t_math;
    iss(OP_LOAD_IMMEDIATE, 4'h9, 4'h0);
    iss(OP_ADD_MEMORY, 4'h0, 4'h8); chk({acc_o, carry_flag_o}, 5'h02);
    iss(OP_SET_CARRY, 4'h0, 4'h0);
    iss(OP_ADD_WITH_CARRY, 4'h0, 4'h6); chk({acc_o, carry_flag_o}, 5'h10);
    iss(OP_ADD_WITH_CARRY, 4'h0, 4'hf); chk({acc_o, carry_flag_o}, 5'h0f);
    iss(OP_AND_MEMORY, 4'h0, 4'h5); chk(acc_o, 4'h5);
    iss(OP_OR_MEMORY, 4'h0, 4'ha); chk(acc_o, 4'hf);
    iss(OP_INVERT_ACCUMULATOR, 4'h0, 4'h0); chk(acc_o, 4'h0);
    iss(OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'h0); chk({acc_o, carry_flag_o}, 5'h10);
  endtask
  task t_bits;
    for (int j = 0; j < 4; j++) begin
      iss(OP_SET_BIT, j[3:0], 4'h0); chk({mem_we_o, mem_wdata_o}, 5'h10 | (5'h01 << j));
      iss(OP_CLEAR_BIT, j[3:0], 4'hf); chk({mem_we_o, mem_wdata_o}, 5'h1f ^ (5'h01 << j));
      iss(OP_SKIP_IF_BIT_ZERO, j[3:0], 4'h1 << j); chk(skip_pending_o, 1'b0);
      iss(OP_SKIP_IF_BIT_ZERO, j[3:0], 4'hf ^ (4'h1 << j)); chk(skip_pending_o, 1'b1);
      iss(OP_NONE, 4'h0, 4'h0);
    end
  endtask
  task t_cmp;
    iss(OP_LOAD_IMMEDIATE, 4'h6, 4'h0);
    iss(OP_SKIP_IF_EQUAL_MEMORY, 4'h0, 4'h6); chk(skip_pending_o, 1'b1);
    iss(OP_NONE, 4'h0, 4'h0);
    iss(OP_SKIP_IF_EQUAL_MEMORY, 4'h0, 4'h7); chk(skip_pending_o, 1'b0);
    iss(OP_SKIP_IF_EQUAL_IMMEDIATE, 4'h6, 4'h0); chk(skip_pending_o, 1'b1);
    iss(OP_NONE, 4'h0, 4'h0);
    iss(OP_SKIP_IF_EQUAL_IMMEDIATE, 4'h5, 4'h0); chk(skip_pending_o, 1'b0);
  endtask
  task t_table;
    iss(OP_LOAD_IMMEDIATE, 4'ha, 4'h0);
    page_i = 5'h15;
    table_addr_i = 3'h3;
    iss(OP_ROM_TABLE_READ, 4'h0, 4'h0);
    chk({rom_req_o, stack_push_o, busy_o, rom_addr_o}, {3'h7, 5'h15, 3'h3, 4'ha});
    // Issued while busy, so it must be ignored
    op_i = OP_SET_CARRY;
    rom_data_i = 8'h3c;
    @(negedge sys_clk_i);
    chk({upper_nibble_o, acc_o}, 8'h3c);
    chk({stack_pop_o, busy_o, carry_flag_o}, 3'h4);
    issue_i = 1'b0;
    @(negedge sys_clk_i);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    t_load;
    t_flags;
    t_math;
    t_bits;
    t_cmp;
    t_table;
    finish_test;
  end
endmodule // tb_top
